// ==== hw/rloc_pkg.sv ====
/*
 * constants, register map and state type for the receiver lock and output control block.
 * assumes a 20 MHz system clock and a link clock near 2.5 MHz sampled by that clock.
 */
package rloc_pkg;

	// timing, each figure in its own unit with the derived cycle count
	localparam int         CLK_PERIOD_NS    = 50;
	localparam int         LINK_TIMEOUT_NS  = 2000;
	localparam logic [5:0] LINK_TIMEOUT_CYC =
		6'((LINK_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int         LOCK_TRY_NS      = 40000;
	localparam logic [9:0] LOCK_TRY_CYC     =
		10'((LOCK_TRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int         OSC_HALF_NS      = 100;
	localparam logic [1:0] OSC_HALF_CYC     =
		2'((OSC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [4:0] LOCK_EDGES       = 5'h10;

	// widths
	localparam int DATA_W      = 8;
	localparam int EQ_W        = 3;
	localparam int IRQ_W       = 3;
	localparam int SLOT_W      = 2;
	localparam int LFSR_W      = 16;
	localparam logic [1:0] STAGGER_LAST = 2'h3;
	localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hace1;

	// register offsets
	localparam logic [7:0] ADDR_CTRL       = 8'h02;
	localparam logic [7:0] ADDR_EQ         = 8'h03;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'h05;
	localparam logic [7:0] ADDR_LINK_STAT  = 8'h06;

	// field positions
	localparam int CTRL_OSC_EN_BIT = 5;
	localparam int EQ_OVR_BIT      = 7;
	localparam int IRQ_LOCK_UP     = 0;
	localparam int IRQ_LOCK_LOST   = 1;
	localparam int IRQ_EQ_STEP     = 2;
	localparam int STAT_LOCK_BIT   = 0;
	localparam int STAT_ACTIVE_BIT = 1;
	localparam int STAT_EQ_LSB     = 4;

	// values after reset
	localparam logic [7:0]       CTRL_RST = 8'h00;
	localparam logic [7:0]       EQ_RST   = 8'h00;
	localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

	// positions of the pins in the synchroniser bundle
	localparam int SYNC_W     = 5;
	localparam int PIN_LCLK   = 0;
	localparam int PIN_LDATA  = 1;
	localparam int PIN_ACTIVE = 2;
	localparam int PIN_DRIVE  = 3;
	localparam int PIN_SEL    = 4;

	// link state, gray along off, acquire, locked
	typedef enum logic [1:0] {
		ST_OFF    = 2'b00,
		ST_ACQ    = 2'b01,
		ST_LOCKED = 2'b11
	} rloc_state_t;

endpackage : rloc_pkg

// ==== hw/rloc_pin_sync.sv ====
/*
 * three-stage synchroniser for a bundle of pins; a bit moves on once stages two and three agree.
 * assumes the bundle is sampled by the system clock and reset by the synchronised reset.
 */
`timescale 1ns/1ps
module rloc_pin_sync #(
	parameter int W = rloc_pkg::SYNC_W
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst_sync_b,
	// pins in, filtered levels out
	input  wire logic [W-1:0] pins,
	output logic      [W-1:0] level
);

	logic [W-1:0] ff1;
	logic [W-1:0] ff2;
	logic [W-1:0] ff3;
	logic [W-1:0] agree;
	logic [W-1:0] next_level;

	// ff1 feeds only ff2; the filter looks at stages two and three
	always_comb
	begin
		agree      = ~(ff2 ^ ff3);
		next_level = (ff3 & agree) | (level & ~agree);
	end

	always_ff @(posedge clock or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			ff1   <= '0;
			ff2   <= '0;
			ff3   <= '0;
			level <= '0;
		end
		else
		begin
			ff1   <= pins;
			ff2   <= ff1;
			ff3   <= ff2;
			level <= next_level;
		end
	end

endmodule : rloc_pin_sync

// ==== hw/rloc_stagger.sv ====
/*
 * staggered output register: each data bit takes its new value in a random slot of a window.
 * assumes loads are further apart than the window; a load inside a window restarts it.
 */
`timescale 1ns/1ps
module rloc_stagger (
	// clock and reset
	input  wire logic                       clock,
	input  wire logic                       rst_sync_b,
	// control
	input  wire logic                       clear,
	input  wire logic                       load,
	input  wire logic [rloc_pkg::DATA_W-1:0] word,
	// staggered result
	output logic      [rloc_pkg::DATA_W-1:0] out
);

	logic [rloc_pkg::LFSR_W-1:0] lfsr;
	logic [rloc_pkg::LFSR_W-1:0] next_lfsr;
	logic [rloc_pkg::LFSR_W-1:0] slots;
	logic [rloc_pkg::LFSR_W-1:0] next_slots;
	logic [rloc_pkg::DATA_W-1:0] pend;
	logic [rloc_pkg::DATA_W-1:0] next_pend;
	logic [rloc_pkg::DATA_W-1:0] next_out;
	logic [rloc_pkg::SLOT_W-1:0] cnt;
	logic [rloc_pkg::SLOT_W-1:0] next_cnt;
	logic                        busy;
	logic                        next_busy;

	// galois lfsr runs freely so slot choices do not repeat per word
	always_comb
	begin
		next_lfsr  = {1'b0, lfsr[rloc_pkg::LFSR_W-1:1]} ^ (lfsr[0] ? 16'hb400 : 16'h0000);
		next_slots = load ? lfsr : slots;
		next_pend  = load ? word : pend;
		next_busy  = busy;
		next_cnt   = cnt;
		if (load)
		begin
			next_busy = 1'b1;
			next_cnt  = '0;
		end
		else if (busy)
		begin
			next_cnt  = cnt + 2'h1;
			next_busy = (cnt != rloc_pkg::STAGGER_LAST);
		end
		if (clear)
		begin
			next_busy = 1'b0;
			next_pend = '0;
		end
	end

	// each bit switches in its own slot, spreading edges over the window
	genvar gi;
	generate
		for (gi = 0; gi < rloc_pkg::DATA_W; gi++)
		begin : g_bit
			assign next_out[gi] = clear ? 1'b0 :
				((busy && slots[gi*2 +: 2] == cnt) ? pend[gi] : out[gi]);
		end
	endgenerate

	always_ff @(posedge clock or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			lfsr  <= rloc_pkg::LFSR_SEED;
			slots <= '0;
			pend  <= '0;
			out   <= '0;
			cnt   <= '0;
			busy  <= 1'b0;
		end
		else
		begin
			lfsr  <= next_lfsr;
			slots <= next_slots;
			pend  <= next_pend;
			out   <= next_out;
			cnt   <= next_cnt;
			busy  <= next_busy;
		end
	end

	// one cycle after the last slot every bit carries the pending word
	property p_stagger_done;
		@(posedge clock) disable iff (!rst_sync_b)
		(busy && cnt == rloc_pkg::STAGGER_LAST && !load && !clear) |=> (out == $past(pend));
	endproperty
	a_stagger_done: assert property (p_stagger_done)
		else $error("staggered word not complete at window end");

endmodule : rloc_stagger

// ==== hw/rloc_top.sv ====
/*
 * receiver lock and output control: link activity, lock sequence, adaptive equaliser level,
 * output drive table, staggered data, small register file and interrupt.
 * assumes the link clock and data, chip_active_input, output_drive_enable and
 * idle_output_state_select arrive asynchronously; register port is on the system clock.
 */
`timescale 1ns/1ps

module rloc_top (
	// clock and reset
	input  wire logic                         clock,
	input  wire logic                         rst_b,
	// link and control pins
	input  wire logic                         link_clock,
	input  wire logic                         link_data,
	input  wire logic                         chip_active_input,
	input  wire logic                         output_drive_enable,
	input  wire logic                         idle_output_state_select,
	// register port
	input  wire logic [7:0]                   reg_addr,
	input  wire logic [7:0]                   reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [7:0]                   reg_rdata,
	// outputs with enables
	output logic                              lock_out,
	output logic                              lock_oe,
	output logic                              pass_out,
	output logic                              pass_oe,
	output logic      [rloc_pkg::DATA_W-1:0]  data_out,
	output logic                              data_oe,
	output logic                              sck_out,
	output logic                              sck_oe,
	// equaliser and interrupt
	output logic      [rloc_pkg::EQ_W-1:0]    eq_level,
	output logic                              irq
);

	logic                          rst_meta_b;
	logic                          rst_sync_b;
	logic [rloc_pkg::SYNC_W-1:0]   pins;
	logic                          lclk;
	logic                          ldata;
	logic                          chip_on;
	logic                          drive_en;
	logic                          sel;
	logic                          lclk_prev;
	logic                          edge_seen;
	logic                          active;
	rloc_pkg::rloc_state_t         state;
	rloc_pkg::rloc_state_t         next_state;
	logic [5:0]                    gap;
	logic [5:0]                    next_gap;
	logic [4:0]                    edges;
	logic [4:0]                    next_edges;
	logic [9:0]                    tries;
	logic [9:0]                    next_tries;
	logic [rloc_pkg::EQ_W-1:0]     eq_auto;
	logic [rloc_pkg::EQ_W-1:0]     next_eq_auto;
	logic                          ev_up;
	logic                          ev_lost;
	logic                          ev_eq;
	logic [rloc_pkg::DATA_W-1:0]   shift;
	logic [rloc_pkg::DATA_W-1:0]   next_shift;
	logic [2:0]                    bits;
	logic [2:0]                    next_bits;
	logic                          word_load;
	logic [rloc_pkg::DATA_W-1:0]   stag_word;
	logic [1:0]                    osc_cnt;
	logic [1:0]                    next_osc_cnt;
	logic                          osc;
	logic                          next_osc;
	logic [7:0]                    ctrl;
	logic [7:0]                    next_ctrl;
	logic [7:0]                    eq_ctrl;
	logic [7:0]                    next_eq_ctrl;
	logic [rloc_pkg::IRQ_W-1:0]    status;
	logic [rloc_pkg::IRQ_W-1:0]    next_status;
	logic [rloc_pkg::IRQ_W-1:0]    mask;
	logic [rloc_pkg::IRQ_W-1:0]    next_mask;
	logic [rloc_pkg::IRQ_W-1:0]    w1c;
	logic [7:0]                    next_rdata;
	logic                          locked;
	logic                          next_lock_out;
	logic                          next_lock_oe;
	logic                          next_pass_out;
	logic                          next_pass_oe;
	logic [rloc_pkg::DATA_W-1:0]   next_data_out;
	logic                          next_data_oe;
	logic                          next_sck_out;
	logic                          next_sck_oe;
	logic                          next_irq;

	// address decode used by the register writes; reads decode reg_addr in a case
	function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
		hit = (a == t);
	endfunction : hit

	// reset release through two flops
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end
		else
		begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	// all pins from outside the clock domain share one synchroniser
	assign pins = {idle_output_state_select, output_drive_enable, chip_active_input,
		link_data, link_clock};

	rloc_pin_sync #(.W(rloc_pkg::SYNC_W)) u_sync (
		.clock      (clock),
		.rst_sync_b (rst_sync_b),
		.pins       (pins),
		.level      ({sel, drive_en, chip_on, ldata, lclk})
	);

	assign edge_seen = lclk && !lclk_prev;
	assign active    = (gap < rloc_pkg::LINK_TIMEOUT_CYC);
	assign locked    = (state == rloc_pkg::ST_LOCKED);
	assign eq_level  = eq_ctrl[rloc_pkg::EQ_OVR_BIT] ? eq_ctrl[rloc_pkg::EQ_W-1:0] : eq_auto;

	// link activity, lock sequence and equaliser stepping
	always_comb
	begin
		next_state   = state;
		next_edges   = edges;
		next_tries   = tries;
		next_eq_auto = eq_auto;
		ev_up        = 1'b0;
		ev_lost      = 1'b0;
		ev_eq        = 1'b0;
		next_gap     = edge_seen ? 6'h00 :
			(active ? gap + 6'h01 : gap);
		case (state)
			rloc_pkg::ST_OFF:
			begin
				next_edges = '0;
				next_tries = '0;
				if (chip_on)
					next_state = rloc_pkg::ST_ACQ;
			end
			rloc_pkg::ST_ACQ:
			begin
				next_tries = tries + 10'h001;
				// an edge after a gap restarts the count at one, so no edge is lost
				if (edge_seen)
				begin
					next_edges = (active ? edges : 5'h00) + 5'h01;
					if (active && edges == rloc_pkg::LOCK_EDGES - 5'h01)
					begin
						next_state = rloc_pkg::ST_LOCKED;
						ev_up      = 1'b1;
					end
				end
				else if (!active)
					next_edges = '0;
				// no lock in time: try the next equaliser gain
				if (tries == rloc_pkg::LOCK_TRY_CYC - 10'h001 && !ev_up)
				begin
					next_tries = '0;
					next_edges = '0;
					ev_eq      = 1'b1;
				end
			end
			rloc_pkg::ST_LOCKED:
			begin
				if (!active)
				begin
					next_state = rloc_pkg::ST_ACQ;
					next_edges = '0;
					next_tries = '0;
					ev_lost    = 1'b1;
				end
			end
			default:
				next_state = rloc_pkg::ST_OFF;
		endcase
		if (ev_eq)
			next_eq_auto = eq_auto + 3'h1;
		// chip inactive drops the lock state and the automatic equaliser level back to their starting point
		if (!chip_on)
		begin
			next_state   = rloc_pkg::ST_OFF;
			next_eq_auto = '0;
			ev_up        = 1'b0;
			ev_eq        = 1'b0;
			ev_lost      = locked;
		end
	end

	// data recovery on link clock rising edges while locked
	always_comb
	begin
		next_shift = shift;
		next_bits  = bits;
		word_load  = 1'b0;
		if (locked && edge_seen)
		begin
			next_shift = {shift[rloc_pkg::DATA_W-2:0], ldata};
			next_bits  = bits + 3'h1;
			word_load  = (bits == 3'h7);
		end
		else if (!locked)
			next_bits = '0;
	end

	rloc_stagger u_stagger (
		.clock      (clock),
		.rst_sync_b (rst_sync_b),
		.clear      (!locked),
		.load       (word_load),
		.word       (next_shift),
		.out        (stag_word)
	);

	// internal oscillator, a divided copy of the system clock
	always_comb
	begin
		next_osc_cnt = osc_cnt + 2'h1;
		next_osc     = osc;
		if (osc_cnt == rloc_pkg::OSC_HALF_CYC - 2'h1)
		begin
			next_osc_cnt = '0;
			next_osc     = !osc;
		end
	end

	// register file; set wins over a write-one clear on the status bits
	always_comb
	begin
		next_ctrl    = ctrl;
		next_eq_ctrl = eq_ctrl;
		next_mask    = mask;
		w1c          = (reg_wr && hit(reg_addr, rloc_pkg::ADDR_IRQ_STATUS)) ?
			reg_wdata[rloc_pkg::IRQ_W-1:0] : '0;
		if (reg_wr && hit(reg_addr, rloc_pkg::ADDR_CTRL))
			next_ctrl = reg_wdata;
		if (reg_wr && hit(reg_addr, rloc_pkg::ADDR_EQ))
			next_eq_ctrl = reg_wdata; // manual level
		if (reg_wr && hit(reg_addr, rloc_pkg::ADDR_IRQ_MASK))
			next_mask = reg_wdata[rloc_pkg::IRQ_W-1:0];
		next_status = (status & ~w1c) | {ev_eq, ev_lost, ev_up};
		next_rdata  = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				rloc_pkg::ADDR_CTRL:       next_rdata = ctrl;
				rloc_pkg::ADDR_EQ:         next_rdata = eq_ctrl;
				rloc_pkg::ADDR_IRQ_STATUS: next_rdata = {5'h00, status};
				rloc_pkg::ADDR_IRQ_MASK:   next_rdata = {5'h00, mask};
				rloc_pkg::ADDR_LINK_STAT:  next_rdata = {1'b0, eq_level, 2'h0, active, locked};
				default:                   next_rdata = 8'h00;
			endcase
		end
		// writes while inactive are lost on purpose; defaults must hold
		if (!chip_on)
		begin
			next_ctrl    = rloc_pkg::CTRL_RST;
			next_eq_ctrl = rloc_pkg::EQ_RST;
			next_mask    = rloc_pkg::MASK_RST;
			next_status  = {1'b0, ev_lost, 1'b0};
		end
		next_irq = |(next_status & next_mask);
	end

	// output drive table
	always_comb
	begin
		next_lock_out = 1'b0;
		next_lock_oe  = 1'b0;
		next_pass_out = 1'b0;
		next_pass_oe  = 1'b0;
		next_data_out = '0;
		next_data_oe  = 1'b0;
		next_sck_out  = 1'b0;
		next_sck_oe   = 1'b0;
		if (chip_on)
		begin
			next_lock_oe  = 1'b1;
			next_lock_out = locked;
			if (!drive_en)
			begin
				next_pass_oe = !sel;
				next_data_oe = !sel;
				next_sck_oe  = !sel;
			end
			else
			begin
				next_pass_oe = 1'b1;
				next_data_oe = 1'b1;
				next_sck_oe  = 1'b1;
				if (!locked)
				begin
					next_pass_out = sel;
					next_sck_out  = !sel && ctrl[rloc_pkg::CTRL_OSC_EN_BIT] && osc;
				end
				else if (sel)
				begin
					next_pass_out = 1'b1;
					next_data_out = stag_word;
					next_sck_out  = lclk;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			state     <= rloc_pkg::ST_OFF;
			lclk_prev <= 1'b0;
			gap       <= rloc_pkg::LINK_TIMEOUT_CYC;
			edges     <= '0;
			tries     <= '0;
			eq_auto   <= '0;
			shift     <= '0;
			bits      <= '0;
			osc_cnt   <= '0;
			osc       <= 1'b0;
			ctrl      <= rloc_pkg::CTRL_RST;
			eq_ctrl   <= rloc_pkg::EQ_RST;
			mask      <= rloc_pkg::MASK_RST;
			status    <= '0;
			reg_rdata <= 8'h00;
			irq       <= 1'b0;
			lock_out  <= 1'b0;
			lock_oe   <= 1'b0;
			pass_out  <= 1'b0;
			pass_oe   <= 1'b0;
			data_out  <= '0;
			data_oe   <= 1'b0;
			sck_out   <= 1'b0;
			sck_oe    <= 1'b0;
		end
		else
		begin
			state     <= next_state;
			lclk_prev <= lclk;
			gap       <= next_gap;
			edges     <= next_edges;
			tries     <= next_tries;
			eq_auto   <= next_eq_auto;
			shift     <= next_shift;
			bits      <= next_bits;
			osc_cnt   <= next_osc_cnt;
			osc       <= next_osc;
			ctrl      <= next_ctrl;
			eq_ctrl   <= next_eq_ctrl;
			mask      <= next_mask;
			status    <= next_status;
			reg_rdata <= next_rdata;
			irq       <= next_irq;
			lock_out  <= next_lock_out;
			lock_oe   <= next_lock_oe;
			pass_out  <= next_pass_out;
			pass_oe   <= next_pass_oe;
			data_out  <= next_data_out;
			data_oe   <= next_data_oe;
			sck_out   <= next_sck_out;
			sck_oe    <= next_sck_oe;
		end
	end

	property p_acq_start;
		@(posedge clock) disable iff (!rst_sync_b)
		(state == rloc_pkg::ST_OFF && chip_on) |=> (state == rloc_pkg::ST_ACQ);
	endproperty
	a_acq_start: assert property (p_acq_start)
		else $error("acquisition did not start");

	property p_lock_drive;
		@(posedge clock) disable iff (!rst_sync_b)
		(locked && chip_on) |=> (lock_out && lock_oe);
	endproperty
	a_lock_drive: assert property (p_lock_drive)
		else $error("lock output not high while locked");

	property p_off_tristate;
		@(posedge clock) disable iff (!rst_sync_b)
		!chip_on |=> (!lock_oe && !pass_oe && !data_oe && !sck_oe);
	endproperty
	a_off_tristate: assert property (p_off_tristate)
		else $error("output driven while chip inactive");

	property p_drive_low;
		@(posedge clock) disable iff (!rst_sync_b)
		(chip_on && !drive_en) |=> (lock_oe && pass_oe == !$past(sel) && data_oe == !$past(sel)
			&& !pass_out && data_out == '0 && !sck_out);
	endproperty
	a_drive_low: assert property (p_drive_low)
		else $error("wrong drive with output enable low");

	property p_static_out;
		@(posedge clock) disable iff (!rst_sync_b)
		(chip_on && drive_en && !locked) |=> (!lock_out && data_out == '0 && pass_out == $past(sel)
			&& (!$past(sel) || !sck_out));
	endproperty
	a_static_out: assert property (p_static_out)
		else $error("wrong static input outputs");

	property p_active_sel0;
		@(posedge clock) disable iff (!rst_sync_b)
		(chip_on && drive_en && !sel && locked) |=> (lock_out && !pass_out && data_out == '0
			&& !sck_out);
	endproperty
	a_active_sel0: assert property (p_active_sel0)
		else $error("outputs not held low while locked");

	property p_eq_step;
		@(posedge clock) disable iff (!rst_sync_b)
		(state == rloc_pkg::ST_ACQ && chip_on && tries == rloc_pkg::LOCK_TRY_CYC - 10'h001
			&& !edge_seen) |=> (eq_auto == $past(eq_auto) + 3'h1 && status[rloc_pkg::IRQ_EQ_STEP]);
	endproperty
	a_eq_step: assert property (p_eq_step)
		else $error("equaliser did not step after failed lock attempt");

	property p_defaults;
		@(posedge clock) disable iff (!rst_sync_b)
		!chip_on |=> (ctrl == rloc_pkg::CTRL_RST && eq_ctrl == rloc_pkg::EQ_RST
			&& mask == rloc_pkg::MASK_RST);
	endproperty
	a_defaults: assert property (p_defaults)
		else $error("registers not at defaults while inactive");

	property p_lock_loss;
		@(posedge clock) disable iff (!rst_sync_b)
		(locked && !active && chip_on) |=> (state == rloc_pkg::ST_ACQ) ##1 !lock_out;
	endproperty
	a_lock_loss: assert property (p_lock_loss)
		else $error("lock held after link went static");

endmodule : rloc_top

// ==== tb/rloc_ser_model.sv ====
/*
 * behavioural serializer at the far end of the link: a 16-edge preamble, then one word
 * repeated msb first for as long as run stays high.
 * assumes the receiver samples link_data on rising link_clock edges.
 */
`timescale 1ns/1ps
module rloc_ser_model (
	// frame control
	input  wire logic       run,
	input  wire logic [7:0] word,
	// link pins
	output logic            link_clock,
	output logic            link_data
);
	// clock stands still low between frames
	initial
	begin
		link_clock = 1'b0;
		link_data  = 1'b0;
	end

	// one frame per rise of run; data changes while the clock is low
	always
	begin
		wait (run === 1'b1);
		repeat (16)
		begin
			link_data = 1'b0;
			#200 link_clock = 1'b1;
			#200 link_clock = 1'b0;
		end
		while (run === 1'b1)
		begin
			for (int i = 7; i >= 0; i--)
			begin
				link_data = word[i];
				#200 link_clock = 1'b1;
				#200 link_clock = 1'b0;
			end
		end
		// released line: show the inverse so a stale value cannot pass
		link_data = ~link_data;
	end
endmodule : rloc_ser_model

// ==== tb/testbench.sv ====
/*
 * self-checking bench for the receiver lock and output control block.
 * assumes the serializer model drives the link and the register port answers the next cycle.
 */
`timescale 1ns/1ps
module testbench;
	logic       clock, rst_b, chip_active_input, output_drive_enable, idle_output_state_select;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
	logic       reg_wr, reg_rd, lock_out, lock_oe, pass_out, pass_oe, data_oe, sck_out, sck_oe;
	logic       link_clock, link_data, irq, run;
	logic [7:0] data_out;
	logic [2:0] eq_level;
	int         n_mismatch = 0;
	int         check_count = 0;

	rloc_top uut (.clock(clock), .rst_b(rst_b), .link_clock(link_clock), .link_data(link_data),
		.chip_active_input(chip_active_input), .output_drive_enable(output_drive_enable),
		.idle_output_state_select(idle_output_state_select), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.lock_out(lock_out), .lock_oe(lock_oe), .pass_out(pass_out), .pass_oe(pass_oe),
		.data_out(data_out), .data_oe(data_oe), .sck_out(sck_out), .sck_oe(sck_oe),
		.eq_level(eq_level), .irq(irq));
	rloc_ser_model ser (.run(run), .word(8'ha5), .link_clock(link_clock),
		.link_data(link_data));

	// 20 MHz system clock
	always #25 clock = ~clock;

	task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			n_mismatch++;
		end
	endtask : chk

	task reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr    <= 1'b0;
	endtask : reg_write

	// read data stands only in the cycle after the strobe
	task reg_read(input logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd   <= 1'b0;
		#1 rd = reg_rdata;
	endtask : reg_read

	// pins go through a synchroniser, so let eight edges pass
	task pins(input logic a, input logic o, input logic s);
		@(posedge clock);
		chip_active_input        <= a;
		output_drive_enable      <= o;
		idle_output_state_select <= s;
		repeat (8) @(posedge clock);
		#1;
	endtask : pins

	task sck_tgl(input logic exp);
		logic hi, lo;
		hi = 1'b0;
		lo = 1'b0;
		repeat (40)
		begin
			@(posedge clock);
			#1 hi = hi | (sck_out === 1'b1);
			lo = lo | (sck_out === 1'b0);
		end
		chk("sck_toggle", {7'h00, exp}, {7'h00, hi & lo});
	endtask : sck_tgl

	task t_off;
		pins(1'b0, 1'b1, 1'b1);
		chk("all_oe", 8'h00, {4'h0, lock_oe, pass_oe, data_oe, sck_oe});
		$display("test off done");
	endtask : t_off

	task t_eq;
		pins(1'b1, 1'b1, 1'b0);
		repeat (900) @(posedge clock);
		chk("eq_auto", 8'h01, {5'h00, eq_level});
		reg_write(rloc_pkg::ADDR_EQ, 8'h85);
		#1 chk("eq_manual", 8'h05, {5'h00, eq_level});
		reg_read(8'h7f);
		chk("unmapped", 8'h00, rd);
		reg_write(rloc_pkg::ADDR_EQ, 8'h80);
		$display("test eq done");
	endtask : t_eq

	task t_static;
		pins(1'b1, 1'b1, 1'b0);
		chk("static_sel0", 8'h02, {4'h0, lock_out, pass_out, data_out === 8'h00, sck_out});
		sck_tgl(1'b0);
		reg_write(rloc_pkg::ADDR_CTRL, 8'h20);
		sck_tgl(1'b1);
		pins(1'b1, 1'b1, 1'b1);
		chk("static_sel1", 8'h06, {4'h0, lock_out, pass_out, data_out === 8'h00, sck_out});
		reg_read(rloc_pkg::ADDR_CTRL);
		chk("ctrl_wr", 8'h20, rd);
		pins(1'b0, 1'b1, 1'b1);
		pins(1'b1, 1'b1, 1'b1);
		reg_read(rloc_pkg::ADDR_CTRL);
		chk("ctrl_default", 8'h00, rd);
		$display("test static done");
	endtask : t_static

	task t_lock;
		reg_write(rloc_pkg::ADDR_IRQ_MASK, 8'h03);
		reg_write(rloc_pkg::ADDR_IRQ_STATUS, 8'h07);
		run <= 1'b1;
		for (int i = 0; i < 400 && lock_out !== 1'b1; i++) @(posedge clock);
		#1 chk("lock", 8'h01, {7'h00, lock_out});
		chk("irq_up", 8'h01, {7'h00, irq});
		reg_read(rloc_pkg::ADDR_LINK_STAT);
		chk("stat_lock", 8'h03, rd & 8'h03);
		reg_write(rloc_pkg::ADDR_IRQ_STATUS, 8'h07);
		repeat (2) @(posedge clock);
		#1 chk("irq_clr", 8'h00, {7'h00, irq});
		repeat (150) @(posedge clock);
		#1 chk("word", 8'ha5, data_out);
		chk("pass_sel1", 8'h03, {6'h00, lock_out, pass_out});
		sck_tgl(1'b1);
		pins(1'b1, 1'b1, 1'b0);
		chk("locked_sel0", 8'h05, {5'h00, lock_out, pass_out, data_out === 8'h00});
		pins(1'b1, 1'b0, 1'b0);
		chk("drv0_sel0", 8'h3c, {2'h0, lock_oe, lock_out, pass_oe, data_oe, pass_out, sck_out});
		pins(1'b1, 1'b0, 1'b1);
		chk("drv0_sel1", 8'h06, {4'h0, pass_oe, lock_oe, lock_out, data_oe | sck_oe});
		$display("test lock done");
	endtask : t_lock

	task t_lost;
		pins(1'b1, 1'b1, 1'b1);
		run <= 1'b0;
		repeat (150) @(posedge clock);
		#1 chk("lost", 8'h03, {5'h00, lock_out, pass_out, data_out === 8'h00});
		chk("irq_lost", 8'h01, {7'h00, irq});
		reg_read(rloc_pkg::ADDR_IRQ_STATUS);
		chk("stat_lost", 8'h02, rd & 8'h02);
		$display("test lost done");
	endtask : t_lost

	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	// main sequence
	initial
	begin
		clock = 1'b0; rst_b = 1'b0; run = 1'b0; chip_active_input = 1'b0;
		output_drive_enable = 1'b0; idle_output_state_select = 1'b0;
		reg_addr = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		repeat (4) @(posedge clock);
		t_off();
		t_eq();
		t_static();
		t_lock();
		t_lost();
		tally_and_finish();
	end

	// watchdog: the tests need well under 5000 cycles
	initial
	begin
		#(50 * 20000);
		n_mismatch++;
		tally_and_finish();
	end
endmodule : testbench
